//--- hw/igs_group_ctrl.v
`timescale 1ns/1ps
`include "igs_defines.vh"

// ----------------------------------------
// cell buffer
// ----------------------------------------
module igs_fifo #(
	parameter W  = `IGS_CELL_W,
	parameter D  = `IGS_FIFO_DEPTH,
	parameter AW = `IGS_FIFO_AW
) (
	// clock and reset
	input  wire          clk,
	input  wire          rst,
	// fill side
	input  wire          in_valid,
	output reg           in_ready,
	input  wire [W-1:0]  in_data,
	// drain side
	output reg           out_valid,
	input  wire          out_ready,
	output reg  [W-1:0]  out_data
);
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	reg  [AW:0]   count;
	reg  [AW:0]   next_count;
	wire          do_wr;
	wire          do_rd;
	wire [AW-1:0] rd_nxt;
	wire [AW-1:0] rd_sel;

	assign do_wr  = in_valid & in_ready;
	assign do_rd  = out_valid & out_ready;
	assign rd_nxt = (rd_ptr == D - 1) ? {AW{1'b0}} : rd_ptr + {{(AW-1){1'b0}}, 1'b1};
	assign rd_sel = do_rd ? rd_nxt : rd_ptr;

	always @* begin
		next_count = count;
		if (do_wr & ~do_rd)
			next_count = count + {{AW{1'b0}}, 1'b1};
		else if (do_rd & ~do_wr)
			next_count = count - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end

	// flags registered from the next count so both ports see honest state
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr    <= {AW{1'b0}};
			rd_ptr    <= {AW{1'b0}};
			count     <= {(AW+1){1'b0}};
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= {W{1'b0}};
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == D - 1) ? {AW{1'b0}} : wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (do_rd)
				rd_ptr <= rd_nxt;
			// head word kept in a flop; bypass covers a write into the slot shown next
			out_data  <= (do_wr && wr_ptr == rd_sel) ? in_data : mem[rd_sel];
			count     <= next_count;
			in_ready  <= (next_count != D);
			out_valid <= (next_count != {(AW+1){1'b0}});
		end
	end
endmodule // igs_fifo

// ----------------------------------------
// group control top
// ----------------------------------------
module igs_group_ctrl #(
	parameter N        = `IGS_LINKS,
	parameter NR       = `IGS_REASONS,
	parameter CW       = `IGS_CELL_W,
	parameter MS_CYC   = `IGS_MS_CYC,
	parameter WAIT_MS  = `IGS_WAIT_MS
) (
	// clock and reset
	input  wire                    clk,
	input  wire                    rst,
	// group state machines
	input  wire [`IGS_GSM_W-1:0]   gsm_local,
	input  wire [`IGS_GSM_W-1:0]   gsm_remote,
	input  wire [NR-1:0]           reason_flags,
	input  wire [`IGS_GSM_W-1:0]   gsc_req,
	// link procedure control
	input  wire                    frame_tick,
	input  wire                    rr_sync,
	input  wire                    startup_req,
	input  wire                    abort,
	input  wire [N-1:0]            cfg_links,
	input  wire [N-1:0]            accept_links,
	input  wire [N-1:0]            insert_req,
	input  wire [N-1:0]            delete_links,
	input  wire [N-1:0]            fe_tx_usable,
	input  wire [N-1:0]            fe_rx_active,
	// group status out
	output reg                     group_up,
	output reg                     reason_valid,
	output reg  [`IGS_REASON_W-1:0] reason_code,
	output reg  [`IGS_GSM_W-1:0]   gsc_tx,
	// traffic notices
	output reg                     um_down,
	output reg                     um_up,
	output reg                     alm_down,
	output reg                     alm_up,
	// procedure status
	output reg                     proc_busy,
	output reg                     lasr_busy,
	output reg                     lasr_start,
	output reg                     proc_done,
	output wire [N*`IGS_LS_W-1:0]  tx_state,
	output wire [N*`IGS_LS_W-1:0]  rx_state,
	// cell stream
	input  wire                    cell_in_valid,
	output wire                    cell_in_ready,
	input  wire [CW-1:0]           cell_in_data,
	output wire                    cell_out_valid,
	input  wire                    cell_out_ready,
	output wire [CW-1:0]           cell_out_data
);
	localparam S_IDLE = 4'h1;
	localparam S_USE  = 4'h2;
	localparam S_RXA  = 4'h4;
	localparam S_TXA  = 4'h8;

	reg  [3:0]               state;
	reg                      mode_lasr;
	reg  [N-1:0]             sel;
	reg  [N-1:0]             pend;
	reg  [15:0]              div_cnt;
	reg  [15:0]              ms_cnt;
	reg                      wait_done;
	reg  [1:0]               gsc_held;
	reg  [`IGS_REASON_W-1:0] next_reason;
	reg                      next_rvalid;
	integer                  k;
	wire                     both_oper;
	wire [N-1:0]             tgt;
	wire                     rx_ok;
	wire                     tx_ok;
	wire                     start_go;
	wire                     lasr_go;
	wire                     do_tx_use;
	wire                     do_rx_act;
	wire                     do_tx_act;
	wire                     do_clr;
	wire                     timer_clr;
	wire [1:0]               held_inc;

	// ----------------------------------------
	// group up/down and reason
	// ----------------------------------------
	assign both_oper = (gsm_local == `IGS_GSM_OPER) & (gsm_remote == `IGS_GSM_OPER);

	// lowest index is the highest priority reason
	always @* begin
		next_reason = {`IGS_REASON_W{1'b0}};
		next_rvalid = 1'b0;
		for (k = NR - 1; k >= 0; k = k - 1) begin
			if (reason_flags[k]) begin
				next_reason = k[`IGS_REASON_W-1:0];
				next_rvalid = 1'b1;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			group_up     <= 1'b0;
			reason_valid <= 1'b0;
			reason_code  <= {`IGS_REASON_W{1'b0}};
			um_down      <= 1'b0;
			um_up        <= 1'b0;
			alm_down     <= 1'b0;
			alm_up       <= 1'b0;
		end else begin
			group_up     <= both_oper;
			reason_valid <= ~both_oper & next_rvalid;
			reason_code  <= both_oper ? {`IGS_REASON_W{1'b0}} : next_reason;
			// only traffic edges reach management, never raw defects
			um_down      <= group_up & ~both_oper;
			alm_down     <= group_up & ~both_oper;
			um_up        <= ~group_up & both_oper;
			alm_up       <= ~group_up & both_oper;
		end
	end

	// ----------------------------------------
	// group status and control field
	// ----------------------------------------
	assign held_inc = (gsc_held == `IGS_MIN_FRAMES) ? gsc_held : gsc_held + 2'h1;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			gsc_tx   <= {`IGS_GSM_W{1'b0}};
			gsc_held <= 2'h0;
		end else if (frame_tick) begin
			if (gsc_req != gsc_tx && held_inc == `IGS_MIN_FRAMES) begin
				gsc_tx   <= gsc_req;
				gsc_held <= 2'h0;
			end else begin
				gsc_held <= held_inc;
			end
		end
	end

	// ----------------------------------------
	// one second wait timer
	// ----------------------------------------
	assign timer_clr = do_tx_use | do_rx_act | do_clr;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt   <= 16'h0000;
			ms_cnt    <= 16'h0000;
			wait_done <= 1'b0;
		end else if (timer_clr) begin
			div_cnt   <= 16'h0000;
			ms_cnt    <= 16'h0000;
			wait_done <= 1'b0;
		end else if (!wait_done) begin
			if (div_cnt == MS_CYC - 1) begin
				div_cnt <= 16'h0000;
				ms_cnt  <= ms_cnt + 16'h0001;
				if (ms_cnt == WAIT_MS - 1)
					wait_done <= 1'b1;
			end else begin
				div_cnt <= div_cnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// start-up / link addition sequencer
	// ----------------------------------------
	// start-up waits on every configured link, addition only on its own
	assign tgt   = mode_lasr ? sel : cfg_links;
	assign rx_ok = wait_done | ((fe_tx_usable & tgt) == tgt);
	assign tx_ok = wait_done | ((fe_rx_active & tgt) == tgt);

	assign start_go  = (state == S_IDLE) & startup_req;
	// addition only begins on a round-robin boundary
	assign lasr_go   = (state == S_IDLE) & ~startup_req & rr_sync
		& ((pend | insert_req) != {N{1'b0}});
	assign do_clr    = (state != S_IDLE) & abort;
	assign do_tx_use = (state == S_USE) & frame_tick & ~abort;
	assign do_rx_act = (state == S_RXA) & frame_tick & rx_ok & ~abort;
	assign do_tx_act = (state == S_TXA) & frame_tick & tx_ok & ~abort;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state      <= S_IDLE;
			mode_lasr  <= 1'b0;
			sel        <= {N{1'b0}};
			pend       <= {N{1'b0}};
			proc_busy  <= 1'b0;
			lasr_busy  <= 1'b0;
			lasr_start <= 1'b0;
			proc_done  <= 1'b0;
		end else begin
			lasr_start <= lasr_go;
			proc_done  <= do_tx_act;
			// requests during a running procedure are held; one arriving with the take goes into sel while pend clears
			if (lasr_go)
				pend <= {N{1'b0}};
			else
				pend <= pend | insert_req;
			case (state)
				S_IDLE: begin
					if (start_go) begin
						sel       <= accept_links;
						mode_lasr <= 1'b0;
						state     <= S_USE;
						proc_busy <= 1'b1;
					end else if (lasr_go) begin
						sel       <= pend | insert_req;
						mode_lasr <= 1'b1;
						state     <= S_USE;
						proc_busy <= 1'b1;
						lasr_busy <= 1'b1;
					end
				end
				S_USE: begin
					if (do_tx_use)
						state <= S_RXA;
				end
				S_RXA: begin
					if (do_rx_act)
						state <= S_TXA;
				end
				S_TXA: begin
					if (do_tx_act)
						state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
			if (do_clr)
				state <= S_IDLE;
			if (do_clr | do_tx_act) begin
				proc_busy <= 1'b0;
				lasr_busy <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// per-link reported states
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_link
			reg [`IGS_LS_W-1:0] tx_ls;
			reg [`IGS_LS_W-1:0] rx_ls;
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					tx_ls <= `IGS_LS_UNUSABLE;
					rx_ls <= `IGS_LS_UNUSABLE;
				end else if ((do_clr & sel[i]) | (frame_tick & delete_links[i])) begin
					tx_ls <= `IGS_LS_UNUSABLE;
					rx_ls <= `IGS_LS_UNUSABLE;
				end else if (sel[i]) begin
					if (do_tx_use)
						tx_ls <= `IGS_LS_USABLE;
					if (do_rx_act)
						rx_ls <= `IGS_LS_ACTIVE;
					if (do_tx_act)
						tx_ls <= `IGS_LS_ACTIVE;
				end
			end
			assign tx_state[i*`IGS_LS_W +: `IGS_LS_W] = tx_ls;
			assign rx_state[i*`IGS_LS_W +: `IGS_LS_W] = rx_ls;
		end
	endgenerate

	// ----------------------------------------
	// cell path
	// ----------------------------------------
	// link changes never flush this buffer; only back-pressure throttles cells
	igs_fifo #(
		.W  (CW),
		.D  (`IGS_FIFO_DEPTH),
		.AW (`IGS_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (cell_in_valid),
		.in_ready  (cell_in_ready),
		.in_data   (cell_in_data),
		.out_valid (cell_out_valid),
		.out_ready (cell_out_ready),
		.out_data  (cell_out_data)
	);
endmodule // igs_group_ctrl

//--- pkg/igs_defines.vh
`ifndef IGS_DEFINES_VH
`define IGS_DEFINES_VH

// ----------------------------------------
// group state machine codes
// ----------------------------------------
`define IGS_GSM_W        3
`define IGS_GSM_OPER     3'h4

// ----------------------------------------
// reported per-link state codes
// ----------------------------------------
`define IGS_LS_W         2
`define IGS_LS_UNUSABLE  2'h0
`define IGS_LS_USABLE    2'h1
`define IGS_LS_ACTIVE    2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define IGS_CLK_HZ       20000000
`define IGS_WAIT_SEC     1
`define IGS_WAIT_MS      (`IGS_WAIT_SEC * 1000)
`define IGS_MS_CYC       (`IGS_CLK_HZ / 1000)
`define IGS_MIN_FRAMES   2'h2

// ----------------------------------------
// sizes
// ----------------------------------------
`define IGS_LINKS        8
`define IGS_REASONS      8
`define IGS_REASON_W     3
`define IGS_CELL_W       8
`define IGS_FIFO_DEPTH   16
`define IGS_FIFO_AW      4

`endif

//--- testbench/igs_fe_model.sv
`timescale 1ns/1ps
`include "igs_defines.vh"

module igs_fe_model #(
	parameter N = `IGS_LINKS
) (
	// clock and reset
	input  logic                   clk,
	input  logic                   rst,
	// near-end states seen in the control cells
	input  logic                   slow,
	input  logic                   frame_tick,
	input  logic [N*`IGS_LS_W-1:0] tx_state,
	input  logic [N*`IGS_LS_W-1:0] rx_state,
	// far-end reports
	output logic [N-1:0]           fe_tx_usable,
	output logic [N-1:0]           fe_rx_active
);
	// echoes one frame late; slow withholds reports so the full wait must run
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fe_tx_usable <= '0;
			fe_rx_active <= '0;
		end else if (frame_tick) begin
			for (int i = 0; i < N; i++) begin
				fe_tx_usable[i] <= !slow && tx_state[2*i+:2] != `IGS_LS_UNUSABLE;
				fe_rx_active[i] <= !slow && rx_state[2*i+:2] == `IGS_LS_ACTIVE;
			end
		end
	end
endmodule // igs_fe_model

//--- testbench/igs_group_ctrl_properties.sv
`timescale 1ns/1ps
`include "igs_defines.vh"

module igs_props #(
	parameter N = `IGS_LINKS
) (
	// clock and reset
	input logic                     clk,
	input logic                     rst,
	// group and procedure inputs
	input logic [`IGS_GSM_W-1:0]    gsm_local,
	input logic [`IGS_GSM_W-1:0]    gsm_remote,
	input logic [`IGS_REASONS-1:0]  reason_flags,
	input logic                     frame_tick,
	input logic                     rr_sync,
	input logic                     abort,
	input logic [N-1:0]             delete_links,
	// status outputs
	input logic                     group_up,
	input logic [`IGS_REASON_W-1:0] reason_code,
	input logic [`IGS_GSM_W-1:0]    gsc_tx,
	input logic                     um_down,
	input logic                     um_up,
	input logic                     alm_down,
	input logic                     alm_up,
	input logic                     proc_busy,
	input logic                     lasr_start,
	input logic [N*`IGS_LS_W-1:0]   tx_state,
	input logic [N*`IGS_LS_W-1:0]   rx_state,
	// cell stream
	input logic                     cell_in_valid,
	input logic                     cell_in_ready,
	input logic                     cell_out_valid,
	input logic                     cell_out_ready
);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	logic [`IGS_GSM_W-1:0] gp;
	logic [1:0]            nt;
	logic [1:0]            ab;
	logic [4:0]            fc;
	wire both = gsm_local == `IGS_GSM_OPER && gsm_remote == `IGS_GSM_OPER;

	function automatic logic [2:0] low(input logic [7:0] f);
		low = 3'h0;
		for (int i = 7; i >= 0; i--) if (f[i]) low = i[2:0];
	endfunction

	// nt starts at the minimum hold of 2: the hold count before reset is unknown
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			gp <= 3'h0;
			nt <= 2'h2;
			ab <= 2'h0;
			fc <= 5'h00;
		end else begin
			gp <= gsc_tx;
			ab <= {ab[0], abort};
			fc <= fc + (cell_in_valid & cell_in_ready) - (cell_out_valid & cell_out_ready);
			if (gsc_tx != gp) nt <= {1'b0, frame_tick};
			else if (frame_tick && nt != 2'h3) nt <= nt + 2'h1;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_UP: assert property (both |=> group_up)
		else $error("group not reported up");
	AST_DOWN: assert property (!both |=> !group_up)
		else $error("group not reported down");
	AST_REASON: assert property (!both && |reason_flags |=> reason_code == low($past(reason_flags)))
		else $error("wrong reason code");
	AST_DN_NOTE: assert property ($fell(group_up) |-> um_down && alm_down)
		else $error("down notice missing");
	AST_ALM_ONLY: assert property (alm_down || alm_up |-> $changed(group_up))
		else $error("stray management notice");
	AST_UP_NOTE: assert property ($rose(group_up) |-> um_up && alm_up)
		else $error("up notice missing");
	AST_GSC: assert property (gsc_tx != gp |-> $past(frame_tick) && nt >= 2'h2)
		else $error("group status changed too early");
	AST_TICK: assert property (ab == 2'h0 && ($changed(tx_state) || $changed(rx_state)) |-> $past(frame_tick))
		else $error("link state changed off an update");
	AST_ONE: assert property (ab == 2'h0 && ~|$past(delete_links) |-> !($changed(tx_state) && $changed(rx_state)))
		else $error("two steps in one update");
	AST_RR: assert property (lasr_start |-> $past(rr_sync) && !$past(proc_busy))
		else $error("addition started badly");
	AST_FULL: assert property (fc == 5'h10 |-> !cell_in_ready)
		else $error("full buffer still ready");
	AST_EMPTY: assert property (cell_out_valid |-> fc != 5'h00)
		else $error("empty buffer shows data");

	cover property ($rose(group_up));
	cover property (lasr_start);
	cover property (fc == 5'h10);
	cover property (gsc_tx != gp);
endmodule // igs_props

//--- testbench/igs_group_ctrl_tb.sv
`timescale 1ns/1ps
`include "igs_defines.vh"

module igs_group_ctrl_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int MSC = 4;
	localparam int WMS = 3;
	localparam int WAIT = MSC * WMS;
	logic        clk = 1'b0, rst = 1'b1, frame_tick = 1'b0, rr_sync = 1'b0, slow = 1'b1;
	logic        startup_req = 1'b0, abort = 1'b0, cell_in_valid = 1'b0, cell_out_ready = 1'b0;
	logic [2:0]  gsm_local = 3'h0, gsm_remote = 3'h0, gsc_req = 3'h0, reason_code, gsc_tx;
	logic [7:0]  reason_flags = 8'h00, cfg_links = 8'hFF, accept_links = 8'h00;
	logic [7:0]  insert_req = 8'h00, delete_links = 8'h00, cell_in_data = 8'h00;
	logic [7:0]  fe_tx_usable, fe_rx_active, cell_out_data, d;
	logic [15:0] tx_state, rx_state, base;
	logic        group_up, reason_valid, um_down, um_up, alm_down, alm_up, proc_busy, up;
	logic        lasr_busy, lasr_start, proc_done, cell_in_ready, cell_out_valid, r;
	logic [31:0] rnd = 32'hBA8F00FF;
	logic [7:0]  q[$];
	int          n_errors = 0, checks = 0, fc = 0, k, t;

	always #25 clk = ~clk;

	// frame and round-robin boundaries
	always @(posedge clk) begin
		#1;
		fc = fc + 1;
		frame_tick = fc % 4 == 0;
		rr_sync = fc % 8 == 2;
	end

	igs_group_ctrl #(.MS_CYC(MSC), .WAIT_MS(WMS)) uut (
		.clk, .rst, .gsm_local, .gsm_remote, .reason_flags, .gsc_req, .frame_tick, .rr_sync,
		.startup_req, .abort, .cfg_links, .accept_links, .insert_req, .delete_links,
		.fe_tx_usable, .fe_rx_active, .group_up, .reason_valid, .reason_code, .gsc_tx,
		.um_down, .um_up, .alm_down, .alm_up, .proc_busy, .lasr_busy, .lasr_start, .proc_done,
		.tx_state, .rx_state, .cell_in_valid, .cell_in_ready, .cell_in_data, .cell_out_valid,
		.cell_out_ready, .cell_out_data
	);

	igs_fe_model fe (.clk, .rst, .slow, .frame_tick, .tx_state, .rx_state, .fe_tx_usable,
		.fe_rx_active);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] lv(input logic [7:0] m, input logic [1:0] c);
		lv = 16'h0000;
		for (int i = 0; i < 8; i++) if (m[i]) lv[2*i+:2] = c;
	endfunction

	function automatic logic [2:0] low(input logic [7:0] f);
		low = 3'h0;
		for (int i = 7; i >= 0; i--) if (f[i]) low = i[2:0];
	endfunction

	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// walks one start-up or addition through its three steps
	task automatic proc(input logic [7:0] sel, input logic [15:0] b, input logic sl);
		slow = sl;
		for (k = 0; k < 200 && tx_state !== (b | lv(sel, 2'h1)); k++) cyc(1);
		chk(tx_state, b | lv(sel, 2'h1));
		chk(rx_state, b);
		for (t = 0; t < 200 && rx_state !== (b | lv(sel, 2'h2)); t++) cyc(1);
		chk(tx_state, b | lv(sel, 2'h1));
		chk(sl ? t >= WAIT : t < WAIT, 1'h1);
		for (t = 0; t < 200 && proc_done !== 1'b1; t++) cyc(1);
		chk({tx_state, rx_state}, {2{b | lv(sel, 2'h2)}});
		chk(sl ? t >= WAIT : t < WAIT, 1'h1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(8);
		rst = 1'b0;
		rnd = lfsr(rnd);
		accept_links = rnd[7:0] & 8'h0F | 8'h01;
		startup_req = 1'b1;
		cyc(1);
		startup_req = 1'b0;
		proc(accept_links, 16'h0000, 1'b1);
		base = lv(accept_links, 2'h2);
		insert_req = 8'h30;
		cyc(1);
		insert_req = 8'h00;
		for (k = 0; k < 50 && lasr_busy !== 1'b1; k++) cyc(1);
		chk(lasr_busy, 1'h1);
		insert_req = 8'h40;
		cyc(1);
		insert_req = 8'h00;
		proc(8'h30, base, 1'b0);
		base = base | lv(8'h30, 2'h2);
		proc(8'h40, base, 1'b0);
		base = base | lv(8'h40, 2'h2);
		insert_req = 8'h80;
		cyc(1);
		insert_req = 8'h00;
		for (k = 0; k < 100 && tx_state !== (base | lv(8'h80, 2'h1)); k++) cyc(1);
		abort = 1'b1;
		cyc(1);
		abort = 1'b0;
		cyc(2);
		chk({tx_state, proc_busy}, {base, 1'b0});
		// addition with a silent far end must sit out both full waits
		insert_req = 8'h80;
		cyc(1);
		insert_req = 8'h00;
		proc(8'h80, base, 1'b1);
		base = base | lv(8'h80, 2'h2);
		// cell traffic while links are deleted in an operational group
		gsm_local = `IGS_GSM_OPER;
		gsm_remote = `IGS_GSM_OPER;
		cyc(1);
		chk({group_up, um_up, alm_up, um_down, alm_down}, 5'h1C);
		delete_links = 8'h30;
		cell_in_valid = 1'b1;
		repeat (20) begin
			rnd = lfsr(rnd);
			cell_in_data = rnd[7:0];
			r = cell_in_ready;
			cyc(1);
			if (r) q.push_back(cell_in_data);
		end
		chk(q.size(), 16);
		cell_in_valid = 1'b0;
		repeat (64) begin
			rnd = lfsr(rnd);
			cell_out_ready = rnd[0];
			r = cell_out_valid & rnd[0];
			d = cell_out_data;
			cyc(1);
			if (r) chk(d, q.pop_front());
		end
		chk(q.size(), 0);
		delete_links = 8'h00;
		base = base & ~lv(8'h30, 2'h3);
		chk({tx_state, rx_state}, {base, base});
		repeat (16) begin
			rnd = lfsr(rnd);
			gsm_local = rnd[0] ? `IGS_GSM_OPER : rnd[3:1];
			gsm_remote = rnd[4] ? `IGS_GSM_OPER : rnd[7:5];
			reason_flags = rnd[15:8] | 8'h80;
			up = gsm_local == `IGS_GSM_OPER && gsm_remote == `IGS_GSM_OPER;
			cyc(3);
			chk(group_up, up);
			chk({reason_valid, reason_code}, up ? 4'h0 : {1'b1, low(reason_flags)});
		end
		repeat (4) begin
			rnd = lfsr(rnd);
			gsc_req = rnd[2:0];
			cyc(2);
		end
		cyc(16);
		chk(gsc_tx, gsc_req);
		end_of_test;
	end

	initial begin
		#(50 * 4000);
		n_errors++;
		end_of_test;
	end
endmodule // igs_group_ctrl_tb

bind igs_group_ctrl igs_props #(.N(N)) u_props (
	.clk, .rst, .gsm_local, .gsm_remote, .reason_flags, .frame_tick, .rr_sync, .abort,
	.delete_links, .group_up, .reason_code, .gsc_tx, .um_down, .um_up, .alm_down, .alm_up,
	.proc_busy, .lasr_start, .tx_state, .rx_state, .cell_in_valid, .cell_in_ready,
	.cell_out_valid, .cell_out_ready
);
